// ---- design/asr_defines.svh ----
/*
 Timing constants for the static memory host controller.
 Assumes a 250 MHz core clock and is included by bare name.
*/
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
`define ASR_CLK_PS 4000
`define ASR_T_SETUP_PS 4000
`define ASR_T_PULSE_PS 25000
`define ASR_T_ACCESS_PS 25000
`define ASR_T_RECOV_PS 10000
`define ASR_SETUP_CYC ((`ASR_T_SETUP_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_PULSE_CYC ((`ASR_T_PULSE_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_ACCESS_CYC ((`ASR_T_ACCESS_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_RECOV_CYC ((`ASR_T_RECOV_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_SYNC_CYC 2
`define ASR_ADDR_W 15
`define ASR_DATA_W 8
`define ASR_CNT_W 4
`define ASR_CNT_ZERO 4'h0
`define ASR_ADDR_ZERO 15'h0000
`define ASR_DATA_ZERO 8'h00
`endif

// ---- design/asr_pkg.sv ----
/*
 Types for the static memory host controller.
 Assumes asr_defines.svh is on the include path.
*/
`include "asr_defines.svh"
package asr_pkg;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_SETUP = 5'h02,
      ST_PULSE = 5'h04,
      ST_READ = 5'h08,
      ST_RECOV = 5'h10
   } asr_state_t;

   typedef struct packed
   {
      logic req;
      logic write;
      logic [`ASR_ADDR_W-1:0] addr;
      logic [`ASR_DATA_W-1:0] wdata;
   } asr_req_t;

   typedef struct packed
   {
      asr_state_t state;
      logic [`ASR_CNT_W-1:0] cnt;
      logic write;
      logic [`ASR_ADDR_W-1:0] addr;
      logic [`ASR_DATA_W-1:0] wdata;
      logic [`ASR_DATA_W-1:0] rdata;
      logic [`ASR_DATA_W-1:0] din_s1;
      logic [`ASR_DATA_W-1:0] din_s2;
      logic chip_select_n;
      logic output_drive_n;
      logic write_strobe_n;
      logic data_oe;
      logic ready;
      logic done;
   } asr_st_t;
endpackage

// ---- design/asr_host.sv ----
/*
 Host controller that drives a 32K x 8 asynchronous static memory by its pins.
 Assumes one clean request per ready cycle and that the memory meets access time.
*/
`include "asr_defines.svh"
module asr_host
   import asr_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire asr_req_t req_i,
   output logic ready_o,
   output logic done_o,
   output logic [`ASR_DATA_W-1:0] rdata_o,
   output logic [`ASR_ADDR_W-1:0] addr_in_o,
   output logic chip_select_n_o,
   output logic output_drive_n_o,
   output logic write_strobe_n_o,
   input wire logic [`ASR_DATA_W-1:0] data_io_i,
   output logic [`ASR_DATA_W-1:0] data_io_o,
   output logic data_io_oe_o
);
   asr_st_t st_reg;
   asr_st_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      // Pin data passes two flops before the capture reads it.
      st_next.din_s1 = data_io_i;
      st_next.din_s2 = st_reg.din_s1;
      case (st_reg.state)
         ST_IDLE:
         begin
            if (req_i.req)
            begin
               st_next.write = req_i.write;
               st_next.addr = req_i.addr;
               st_next.wdata = req_i.wdata;
               st_next.ready = 1'b0;
               st_next.state = ST_SETUP;
               st_next.cnt = `ASR_CNT_W'(`ASR_SETUP_CYC);
               // Write data goes onto the bus a cycle before select and strobe fall.
               st_next.data_oe = req_i.write;
            end
         end
         ST_SETUP:
         begin
            if (st_reg.cnt > `ASR_CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - `ASR_CNT_W'(1);
            end
            else
            begin
               st_next.chip_select_n = 1'b0;
               if (st_reg.write)
               begin
                  st_next.write_strobe_n = 1'b0;
                  st_next.state = ST_PULSE;
                  st_next.cnt = `ASR_CNT_W'(`ASR_PULSE_CYC);
               end
               else
               begin
                  st_next.output_drive_n = 1'b0;
                  st_next.state = ST_READ;
                  st_next.cnt = `ASR_CNT_W'(`ASR_ACCESS_CYC + `ASR_SYNC_CYC);
               end
            end
         end
         ST_PULSE:
         begin
            if (st_reg.cnt > `ASR_CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - `ASR_CNT_W'(1);
            end
            else
            begin
               st_next.write_strobe_n = 1'b1;
               st_next.state = ST_RECOV;
               st_next.cnt = `ASR_CNT_W'(`ASR_RECOV_CYC);
            end
         end
         ST_READ:
         begin
            if (st_reg.cnt > `ASR_CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - `ASR_CNT_W'(1);
            end
            else
            begin
               // The synchroniser lags the pins by two edges, so this byte was sampled
               // after select and output enable had been low for the whole access time.
               st_next.rdata = st_reg.din_s2;
               st_next.output_drive_n = 1'b1;
               st_next.chip_select_n = 1'b1;
               st_next.state = ST_RECOV;
               st_next.cnt = `ASR_CNT_W'(`ASR_RECOV_CYC);
            end
         end
         ST_RECOV:
         begin
            // Select rises one cycle after the strobe; data stays until recovery ends.
            st_next.chip_select_n = 1'b1;
            if (st_reg.cnt > `ASR_CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - `ASR_CNT_W'(1);
            end
            else
            begin
               st_next.data_oe = 1'b0;
               st_next.ready = 1'b1;
               st_next.done = 1'b1;
               st_next.state = ST_IDLE;
            end
         end
         default:
         begin
            st_next.state = ST_IDLE;
         end
      endcase
      // A low enable holds every field, so a stalled access only grows longer.
      if (!clk_en_i)
      begin
         st_next = st_reg;
      end
      // Reset parks the pins in standby with the data bus released.
      if (reset_i)
      begin
         st_next = '0;
         st_next.state = ST_IDLE;
         st_next.chip_select_n = 1'b1;
         st_next.output_drive_n = 1'b1;
         st_next.write_strobe_n = 1'b1;
         st_next.ready = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      st_reg <= st_next;
   end

   assign ready_o = st_reg.ready;
   assign done_o = st_reg.done;
   assign rdata_o = st_reg.rdata;
   assign addr_in_o = st_reg.addr;
   assign chip_select_n_o = st_reg.chip_select_n;
   assign output_drive_n_o = st_reg.output_drive_n;
   assign write_strobe_n_o = st_reg.write_strobe_n;
   assign data_io_o = st_reg.wdata;
   assign data_io_oe_o = st_reg.data_oe;

   // The checks below watch the pin sequence that the host promises the memory.
   a_read_no_strobe: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !output_drive_n_o |-> write_strobe_n_o)
      else $error("strobe low while output enabled");
   a_write_oe_high: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !write_strobe_n_o |-> output_drive_n_o && data_io_oe_o)
      else $error("write without drive or with output enable");
   a_no_contend: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !output_drive_n_o |-> !data_io_oe_o)
      else $error("bus contention");
   a_strobe_in_sel: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !write_strobe_n_o |-> !chip_select_n_o)
      else $error("strobe outside select");
   a_oe_in_sel: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !output_drive_n_o |-> !chip_select_n_o)
      else $error("output enable outside select");
   a_pulse_len: assert property (@(posedge core_clk_i)
      disable iff (reset_i || !clk_en_i) $fell(write_strobe_n_o) |-> !write_strobe_n_o [*7])
      else $error("strobe pulse short");
   a_strobe_ends: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $rose(write_strobe_n_o) |-> !chip_select_n_o)
      else $error("select rose before the strobe");
   a_read_window: assert property (@(posedge core_clk_i)
      disable iff (reset_i || !clk_en_i) $fell(output_drive_n_o) |-> !output_drive_n_o [*8])
      else $error("read window short");
   a_addr_stable: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !chip_select_n_o && !$past(chip_select_n_o) |-> $stable(addr_in_o))
      else $error("address moved during select");
   a_data_hold: assert property (@(posedge core_clk_i)
      disable iff (reset_i || !clk_en_i)
      $rose(write_strobe_n_o) |-> data_io_oe_o && $stable(data_io_o))
      else $error("data not held at write end");
   a_drive_release: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(data_io_oe_o) |-> chip_select_n_o && write_strobe_n_o)
      else $error("bus released inside the access");
   a_setup_first: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(chip_select_n_o) |-> $stable(addr_in_o)
         && (write_strobe_n_o || ($past(data_io_oe_o) && $stable(data_io_o))))
      else $error("inputs not set up before select");
   a_sel_release: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $rose(chip_select_n_o) |-> output_drive_n_o && write_strobe_n_o)
      else $error("strobe active at deselect");
   a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ready_o |-> chip_select_n_o && output_drive_n_o && write_strobe_n_o)
      else $error("idle bus not quiet");

   // Covers mark the main access kinds, a stall and a release of reset.
   c_write: cover property (@(posedge core_clk_i) $rose(write_strobe_n_o));
   c_read: cover property (@(posedge core_clk_i) $rose(output_drive_n_o));
   c_done: cover property (@(posedge core_clk_i) done_o);
   c_stall: cover property (@(posedge core_clk_i) !clk_en_i && !chip_select_n_o);
   c_reset: cover property (@(posedge core_clk_i) $fell(reset_i));
endmodule // asr_host

// ---- verif/asr_sram_model.sv ----
/*
 Behavioural 32K x 8 static memory seen from the host's pins.
 Assumes the bench feeds bus_o back to the host as the resolved data wire.
*/
module asr_sram_model
#(parameter int DLY = 3)
(
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [14:0] addr_i,
   input wire logic [7:0] host_d_i,
   input wire logic host_oe_i,
   output logic [7:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [32768];
   logic [7:0] dev_q;
   logic [7:0] held = 8'h00;
   logic drive;
   assign drive = !cs_n_i && !oe_n_i && we_n_i;
   assign #DLY dev_q = mem[addr_i];
   // A released wire shows the inverse of its last driven value.
   always @*
   begin
      if (host_oe_i)
         bus_o = host_d_i;
      else if (drive)
         bus_o = dev_q;
      else
         bus_o = ~held;
   end
   always @(bus_o)
   begin
      if (host_oe_i || drive)
         held = bus_o;
   end
   always @(posedge cs_n_i or posedge we_n_i)
   begin
      if (!cs_n_i || !we_n_i)
         mem[addr_i] = bus_o;
   end
endmodule // asr_sram_model

// ---- verif/tb_asr_host.sv ----
/*
 Self-checking bench for the static memory host controller.
 Assumes the design files and the memory model are compiled first.
*/
module tb_asr_host
   import asr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst;
   logic en;
   asr_req_t req;
   logic ready, done, cs_n, oe_n, we_n, doe;
   logic [7:0] rdata, dout, bus;
   logic [14:0] addr;
   int errors = 0;
   int comparisons = 0;
   asr_host uut (.core_clk_i(clk), .reset_i(rst), .clk_en_i(en), .req_i(req),
      .ready_o(ready), .done_o(done), .rdata_o(rdata), .addr_in_o(addr),
      .chip_select_n_o(cs_n), .output_drive_n_o(oe_n), .write_strobe_n_o(we_n),
      .data_io_i(bus), .data_io_o(dout), .data_io_oe_o(doe));
   asr_sram_model #(.DLY(3)) mem_dev (.cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .addr_i(addr), .host_d_i(dout), .host_oe_i(doe), .bus_o(bus));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Outputs are read at each edge before that edge's updates land.
   // Clock enable drops for stall edges from the fourth edge after the take.
   task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d,
      input int stall);
      int n = 0;
      int we_lo = 0;
      int cs_lo = 0;
      int oe_lo = 0;
      int bad = 0;
      @(posedge clk);
      check(ready, 1'b1);
      req <= '{1'b1, wr, a, d};
      @(posedge clk);
      req.req <= 1'b0;
      while (done !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         n++;
         en <= !(n >= 3 && n < 3 + stall);
         we_lo += (we_n === 1'b0) ? 1 : 0;
         cs_lo += (cs_n === 1'b0) ? 1 : 0;
         oe_lo += (oe_n === 1'b0) ? 1 : 0;
         if (cs_n === 1'b0 && (addr !== a || doe !== wr || (wr && dout !== d)))
            bad++;
      end
      check(n, (wr ? 12 : 14) + stall);
      check(we_lo, wr ? 7 + stall : 0);
      check(cs_lo, (wr ? 8 : 9) + stall);
      check(oe_lo, wr ? 0 : 9 + stall);
      check(bad, 0);
      if (!wr)
         check(rdata, d);
      if (n >= 40)
      begin
         errors++;
         complete_run();
      end
   endtask
   task automatic test_idle();
      check({cs_n, we_n, oe_n, doe, ready, done}, 6'b111010);
      repeat (10)
      begin
         @(posedge clk);
         check(cs_n, 1'b1);
      end
      $display("test idle done");
   endtask
   task automatic test_bounds();
      access(1'b1, 15'h0000, 8'ha5, 0);
      access(1'b1, 15'h7fff, 8'h5a, 0);
      access(1'b0, 15'h0000, 8'ha5, 0);
      access(1'b0, 15'h7fff, 8'h5a, 0);
      $display("test bounds done");
   endtask
   task automatic test_overwrite();
      access(1'b1, 15'h0001, 8'h3c, 0);
      access(1'b1, 15'h0001, 8'hc3, 0);
      access(1'b0, 15'h0001, 8'hc3, 0);
      access(1'b0, 15'h0000, 8'ha5, 0);
      $display("test overwrite done");
   endtask
   task automatic test_stall();
      access(1'b1, 15'h2a55, 8'h96, 3);
      access(1'b0, 15'h2a55, 8'h96, 2);
      $display("test stall done");
   endtask
   task automatic test_retain();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check({cs_n, we_n, oe_n, doe, ready, done}, 6'b111010);
      access(1'b0, 15'h0001, 8'hc3, 0);
      $display("test retain done");
   endtask
   initial
   begin
      rst <= 1'b1;
      en <= 1'b1;
      req <= '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      test_idle();
      test_bounds();
      test_overwrite();
      test_stall();
      test_retain();
      complete_run();
   end
endmodule // tb_asr_host
